/* design/dsg_top.sv */
// Output gating, lock timing and loss detection of the three-lane deserializer.
`timescale 1ns/100ps
`default_nettype none
`include "dsg_params.svh"

module dsg_top #(
	parameter int LOCK_PERIODS = `DSG_LOCK_PERIODS
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Pins from outside the domain
	input wire logic power_down_n,
	input wire logic balance_mode_select,
	input wire logic lvds_clock_in,
	input wire logic [`DSG_LANES-1:0] lvds_data_open,
	input wire logic lvds_clock_open,
	// Lane words from the serial front end
	input wire logic [`DSG_WORD_W-1:0] lvds_data_in_0,
	input wire logic [`DSG_WORD_W-1:0] lvds_data_in_1,
	input wire logic [`DSG_WORD_W-1:0] lvds_data_in_2,
	// Parallel outputs
	output logic [`DSG_OUT_W-1:0] parallel_data_out,
	output logic parallel_data_oe_n,
	output logic parallel_clock_out,
	output logic parallel_clock_oe_n,
	output logic locked
);

	// ****************************************
	// Synchronisers
	// ****************************************
	localparam int SYNC_W = 4 + `DSG_LANES + 3 * `DSG_WORD_W;
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {power_down_n, balance_mode_select, lvds_clock_in, lvds_clock_open,
				lvds_data_open, lvds_data_in_2, lvds_data_in_1, lvds_data_in_0};
			sync2_q <= sync1_q;
		end
	end

	logic pd_n_s;
	logic bal_s;
	logic clk_s;
	logic clk_open_s;
	logic [`DSG_LANES-1:0] lane_open_s;
	logic [3*`DSG_WORD_W-1:0] words_s;
	assign {pd_n_s, bal_s, clk_s, clk_open_s, lane_open_s, words_s} = sync2_q;

	// ****************************************
	// Input clock edges
	// ****************************************
	logic clk_prev_q;
	logic clk_rise;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			clk_prev_q <= 1'b0;
		end else begin
			clk_prev_q <= clk_s;
		end
	end

	assign clk_rise = clk_s && !clk_prev_q;

	// ****************************************
	// Mode and loss detection
	// ****************************************
	// Mode pin pulls high when open, so an undriven pin reads as balanced
	logic balanced;
	assign balanced = bal_s;

	// Frequency detector: no edge within the loss window means stopped or too slow
	dsg_pkg::dsg_loss_cnt_t loss_cnt_q;
	logic freq_lost;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			loss_cnt_q <= '0;
		end else if (clk_rise) begin
			loss_cnt_q <= '0;
		end else if (loss_cnt_q != dsg_pkg::dsg_loss_cnt_t'(`DSG_LOSS_CYCLES)) begin
			loss_cnt_q <= loss_cnt_q + 5'h01;
		end
	end

	assign freq_lost = loss_cnt_q == dsg_pkg::dsg_loss_cnt_t'(`DSG_LOSS_CYCLES);

	logic clock_lost;
	// Open-input forcing only counts outside balanced mode
	assign clock_lost = balanced ? freq_lost : clk_open_s;

	// ****************************************
	// Lock state machine
	// ****************************************
	dsg_pkg::dsg_state_e state_q;
	dsg_pkg::dsg_lock_cnt_t lock_cnt_q;
	logic lock_done;

	assign lock_done = lock_cnt_q == dsg_pkg::dsg_lock_cnt_t'(LOCK_PERIODS - 1);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_q <= dsg_pkg::DSG_OFF;
		end else if (!pd_n_s) begin
			state_q <= dsg_pkg::DSG_OFF;
		end else begin
			unique case (state_q)
				dsg_pkg::DSG_OFF: begin
					state_q <= dsg_pkg::DSG_ACQ;
				end
				dsg_pkg::DSG_ACQ: begin
					// Counting waits for edges, so a late clock only delays lock
					if (clock_lost) begin
						state_q <= dsg_pkg::DSG_ACQ;
					end else if (clk_rise && lock_done) begin
						state_q <= dsg_pkg::DSG_RUN;
					end
				end
				dsg_pkg::DSG_RUN: begin
					if (clock_lost) begin
						state_q <= dsg_pkg::DSG_ACQ;
					end
				end
				default: begin
					state_q <= dsg_pkg::DSG_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			lock_cnt_q <= '0;
		end else if (!pd_n_s || clock_lost || state_q != dsg_pkg::DSG_ACQ) begin
			lock_cnt_q <= '0;
		end else if (clk_rise && !lock_done) begin
			lock_cnt_q <= lock_cnt_q + 16'h0001;
		end
	end

	// ****************************************
	// Lanes
	// ****************************************
	logic [`DSG_OUT_W-1:0] payload_all;

	genvar g;
	generate
		for (g = 0; g < `DSG_LANES; g++) begin : g_lane
			dsg_lane u_lane (
				.ref_clk(ref_clk),
				.reset(reset),
				.capture(clk_rise),
				.balanced(balanced),
				.lane_open(lane_open_s[g]),
				.word(words_s[g*`DSG_WORD_W +: `DSG_WORD_W]),
				.payload(payload_all[g*`DSG_PAYLOAD_W +: `DSG_PAYLOAD_W])
			);
		end
	endgenerate

	// ****************************************
	// Output gating
	// ****************************************
	logic run;
	// Power-down drops the lock flag on the same edge that releases the outputs
	assign run = state_q == dsg_pkg::DSG_RUN && !clock_lost && pd_n_s;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			parallel_data_oe_n <= 1'b1;
			parallel_clock_oe_n <= 1'b1;
		end else begin
			parallel_data_oe_n <= state_q == dsg_pkg::DSG_OFF || !pd_n_s;
			parallel_clock_oe_n <= state_q == dsg_pkg::DSG_OFF || !pd_n_s;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			parallel_data_out <= '0;
			parallel_clock_out <= 1'b0;
			locked <= 1'b0;
		end else if (!run) begin
			// Held low while acquiring or after loss, so the bus never sees stale data
			parallel_data_out <= '0;
			parallel_clock_out <= 1'b0;
			locked <= 1'b0;
		end else begin
			parallel_data_out <= payload_all;
			parallel_clock_out <= clk_prev_q;
			locked <= 1'b1;
		end
	end

endmodule
`default_nettype wire

/* design/dsg_params.svh */
// Constants of the deserializer output gating and lock block.
`ifndef DSG_PARAMS_SVH
`define DSG_PARAMS_SVH

// ****************************************
// Geometry
// ****************************************
`define DSG_LANES 3
`define DSG_PAYLOAD_W 7
`define DSG_WORD_W 9
`define DSG_OUT_W 21
`define DSG_IND_HI 8
`define DSG_IND_LO 7
`define DSG_MAX_DSV 10

// ****************************************
// Timing
// ****************************************
`define DSG_CLK_PERIOD_NS 50
`define DSG_LOCK_PERIODS 32800
`define DSG_LOSS_TIME_NS 1000
`define DSG_LOSS_CYCLES ((`DSG_LOSS_TIME_NS + `DSG_CLK_PERIOD_NS - 1) / `DSG_CLK_PERIOD_NS)
`define DSG_MUX_GAP_NS 100
`define DSG_MUX_GAP_CYCLES ((`DSG_MUX_GAP_NS + `DSG_CLK_PERIOD_NS - 1) / `DSG_CLK_PERIOD_NS)

`endif

/* design/dsg_pkg.sv */
// Types of the deserializer output gating and lock block.
`default_nettype none
package dsg_pkg;
	typedef enum logic [1:0] {
		DSG_OFF = 2'b00,
		DSG_ACQ = 2'b01,
		DSG_RUN = 2'b10
	} dsg_state_e;

	typedef logic [15:0] dsg_lock_cnt_t;
	typedef logic [4:0] dsg_loss_cnt_t;
endpackage
`default_nettype wire

/* design/dsg_lane.sv */
// One lane: payload recovery and per-lane forcing.
`timescale 1ns/100ps
`default_nettype none
`include "dsg_params.svh"

module dsg_lane (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Control
	input wire logic capture,
	input wire logic balanced,
	input wire logic lane_open,
	// Data
	input wire logic [`DSG_WORD_W-1:0] word,
	output logic [`DSG_PAYLOAD_W-1:0] payload
);

	// ****************************************
	// Decode
	// ****************************************
	// Indicator pair 10 marks an inverted group; 01 or anything else passes as sent
	function automatic logic [`DSG_PAYLOAD_W-1:0] restore(input logic [`DSG_WORD_W-1:0] w);
		if (w[`DSG_IND_HI] && !w[`DSG_IND_LO]) begin
			restore = ~w[`DSG_PAYLOAD_W-1:0];
		end else begin
			restore = w[`DSG_PAYLOAD_W-1:0];
		end
	endfunction

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			payload <= '0;
		end else if (capture) begin
			if (!balanced && lane_open) begin
				payload <= '0;
			end else if (balanced) begin
				payload <= restore(word);
			end else begin
				payload <= word[`DSG_PAYLOAD_W-1:0];
			end
		end
	end

endmodule
`default_nettype wire

/* sim/dsg_top_properties.sv */
// Checker on the ports of the gating and lock block.
`timescale 1ns/100ps
`default_nettype none
`include "dsg_params.svh"
module dsg_top_properties #(
	parameter int LOCK_PERIODS = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Pins
	input wire logic power_down_n,
	input wire logic balance_mode_select,
	input wire logic lvds_clock_in,
	input wire logic [`DSG_LANES-1:0] lvds_data_open,
	input wire logic lvds_clock_open,
	input wire logic [`DSG_WORD_W-1:0] lvds_data_in_0,
	input wire logic [`DSG_WORD_W-1:0] lvds_data_in_1,
	input wire logic [`DSG_WORD_W-1:0] lvds_data_in_2,
	// Outputs
	input wire logic [`DSG_OUT_W-1:0] parallel_data_out,
	input wire logic parallel_data_oe_n,
	input wire logic parallel_clock_out,
	input wire logic parallel_clock_oe_n,
	input wire logic locked
);
	// ********
	// Idle counters, saturating so a long stop never wraps
	// ********
	logic prev_q;
	logic [5:0] still_q;
	logic [5:0] open_q;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			prev_q <= 1'h0;
			still_q <= 6'h0;
		end else begin
			prev_q <= lvds_clock_in;
			still_q <= (lvds_clock_in != prev_q) ? 6'h0 : still_q + 6'(still_q != 6'h3f);
		end
	end
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			open_q <= 6'h0;
		else
			open_q <= (!balance_mode_select && lvds_data_open[1]) ? open_q + 6'(open_q != 6'h3f) : 6'h0;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence pd_held;
		!power_down_n [*5];
	endsequence
	sequence pd_up;
		$rose(power_down_n);
	endsequence
	pd_hiz_a: assert property (pd_held |-> parallel_data_oe_n && parallel_clock_oe_n)
		else $error("outputs driven in power-down");
	pd_drive_a: assert property (power_down_n [*6] |-> !parallel_data_oe_n)
		else $error("outputs not driven after power-up");
	idle_low_a: assert property ((!locked && !parallel_data_oe_n) [*2] |->
		parallel_data_out == 21'h0 && !parallel_clock_out)
		else $error("outputs not low before lock");
	lock_drive_a: assert property (locked |-> !parallel_data_oe_n && !parallel_clock_oe_n)
		else $error("locked while outputs released");
	relock_gap_a: assert property (pd_up |-> !locked [*8])
		else $error("lock reported too early");
	clk_stop_a: assert property (balance_mode_select && still_q >= 6'h1a |-> !locked)
		else $error("lock kept with stopped clock");
	clk_open_a: assert property ((!balance_mode_select && lvds_clock_open) [*6] |-> !locked)
		else $error("lock kept with open clock");
	lane_open_a: assert property (open_q >= 6'h14 |-> parallel_data_out[13:7] == 7'h0)
		else $error("open lane outputs not low");
	bal_keep_a: assert property ((balance_mode_select && power_down_n) [*5] ##0
		(locked && still_q < 6'h5) |=> locked)
		else $error("lock lost in balanced mode");
	clk_follow_a: assert property (locked |-> parallel_clock_out == $past(lvds_clock_in, 4))
		else $error("clock output does not follow input clock");
endmodule
bind dsg_top dsg_top_properties #(.LOCK_PERIODS(LOCK_PERIODS)) dsg_top_properties_inst (.*);
`default_nettype wire

/* sim/dsg_ser_model.sv */
// Behavioural serializer feeding the lane words and clock.
`timescale 1ns/100ps
`default_nettype none
module dsg_ser_model (
	// Bench control
	input wire logic run,
	input wire logic inv,
	input wire logic [20:0] pl,
	// Link side
	output logic clk_o,
	output logic [8:0] w0,
	output logic [8:0] w1,
	output logic [8:0] w2
);
	function automatic logic [8:0] enc(input logic [6:0] p, input logic i);
		return i ? {2'b10, ~p} : {2'b01, p};
	endfunction
	initial begin
		{clk_o, w0, w1, w2} = 28'h0;
		#13;
		forever begin
			#100;
			// A stopped sender leaves lanes wandering, not holding
			w0 = run ? enc(pl[6:0], inv) : ~w0;
			w1 = run ? enc(pl[13:7], inv) : ~w1;
			w2 = run ? enc(pl[20:14], inv) : ~w2;
			#100 clk_o = run;
			#200 clk_o = 1'h0;
		end
	end
endmodule
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench of the gating and lock block.
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic ref_clk = 0, reset = 1, power_down_n = 0, balance_mode_select = 1;
	logic lvds_clock_open = 0, run = 0, inv = 0, lvds_clock_in;
	logic [2:0] lvds_data_open = 3'h0;
	logic [8:0] lvds_data_in_0, lvds_data_in_1, lvds_data_in_2;
	logic [20:0] pl = 21'h0, v, parallel_data_out;
	logic parallel_data_oe_n, parallel_clock_out, parallel_clock_oe_n, locked;
	logic [23:0] q[$];
	logic [23:0] n;
	int bad_count = 0, cmp_count = 0;
	always #25 ref_clk = ~ref_clk;
	dsg_top #(.LOCK_PERIODS(8)) dsg_top_inst (.*);
	dsg_ser_model dsg_ser_model_inst (.run, .inv, .pl, .clk_o(lvds_clock_in),
		.w0(lvds_data_in_0), .w1(lvds_data_in_1), .w2(lvds_data_in_2));
	task cyc(input int c);
		repeat (c) @(posedge ref_clk);
	endtask
	task check(input logic [22:0] seen, input logic [22:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL outputs exp %h seen %h", exp, seen);
		end
	endtask
	task stop_test();
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task note(input logic m, input logic lk, input logic oe, input logic [20:0] d);
		q.push_back({m, lk, oe, d});
		cyc(2);
	endtask
	task wait_lock();
		int i;
		for (i = 0; i < 300 && locked !== 1'b1; i++) cyc(1);
		if (i == 300) bad_count++;
		if (i == 300) stop_test();
	endtask
	// Three frames let the sync stages settle before the note
	task frame(input logic iv, input logic [20:0] m);
		v = 21'($urandom);
		pl <= v;
		inv <= iv;
		cyc(24);
		note(1, 1, 0, v & m);
	endtask
	always @(negedge ref_clk) begin
		if (q.size() > 0) begin
			n = q.pop_front();
			check({locked, parallel_data_oe_n, parallel_data_out & {21{n[23]}}}, n[22:0]);
		end
	end
	initial begin
		v = 21'($urandom(32'h94c5a5fe));
		cyc(5);
		reset <= 0;
		cyc(6);
		note(0, 0, 1, 0);
		power_down_n <= 1;
		run <= 1;
		cyc(24);
		note(1, 0, 0, 0);
		wait_lock();
		for (int i = 0; i < 4; i++) frame(i[0], 21'h1fffff);
		$display("test lock_balanced done");
		power_down_n <= 0;
		cyc(6);
		note(0, 0, 1, 0);
		power_down_n <= 1;
		cyc(24);
		note(1, 0, 0, 0);
		wait_lock();
		frame(1, 21'h1fffff);
		$display("test relock done");
		run <= 0;
		cyc(40);
		note(1, 0, 0, 0);
		run <= 1;
		wait_lock();
		frame(0, 21'h1fffff);
		$display("test clock_stop done");
		balance_mode_select <= 0;
		lvds_data_open <= 3'h2;
		frame(0, 21'h1fc07f);
		balance_mode_select <= 1;
		lvds_clock_open <= 1;
		frame(0, 21'h1fffff);
		balance_mode_select <= 0;
		cyc(10);
		note(1, 0, 0, 0);
		$display("test open_inputs done");
		cyc(4);
		stop_test();
	end
endmodule
`default_nettype wire
